/* src/ccr_top.sv */
// Two up/down pulse counters with comparators, reactions and Avalon-MM registers
`timescale 1ns/10ps

module ccr_top
  import ccr_pkg::*;
#(
  parameter int NCNT = 2
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Sensor pins, asynchronous
  input wire ccr_pins_t [NCNT-1:0] sensor_pins,
  // Actuator outputs and interrupt
  output logic [NCNT-1:0] digital_out,
  output logic irq
);

  // Reset release through two flops
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Byte-lane merge for writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    return r;
  endfunction : be_merge

  // Output action of one event on the current level
  function automatic logic do_apply(input logic [1:0] act, input logic cur);
    case (act)
      CCR_DO_ON: do_apply = 1'b1;
      CCR_DO_OFF: do_apply = 1'b0;
      CCR_DO_TOGGLE: do_apply = ~cur;
      default: do_apply = cur;
    endcase
  endfunction : do_apply

  // True when any reaction is configured for the event
  function automatic logic has_react(input ccr_react_t r);
    has_react = r.set_cmp | r.reload | r.irq | (r.dout != CCR_DO_KEEP);
  endfunction : has_react

  // Pin synchronisers plus edge-detect history (third stage)
  ccr_pins_t [NCNT-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end
    else
    begin
      pin_s1_reg <= sensor_pins;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // Register and counter state
  ccr_cfg_t [NCNT-1:0] cfg_reg, cfg_next;
  logic [NCNT-1:0][31:0] rstval_reg, rstval_next;
  logic [NCNT-1:0][31:0] preset_reg, preset_next;
  logic [NCNT-1:0][31:0] count_reg, count_next;
  logic [NCNT-1:0][31:0] comp_reg, comp_next;
  logic [NCNT-1:0] setcmp_old_reg, setcmp_old_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [CCR_IRQ_W-1:0] stat_reg, stat_next;
  logic [CCR_IRQ_W-1:0] irq_en_reg, irq_en_next;
  logic [NCNT-1:0] dout_reg, dout_next;
  logic irq_reg, irq_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wait_reg, wait_next;

  // Combinational view of counting and events
  logic [NCNT-1:0] up_edge, dn_edge, ev_reach, ev_fall;
  logic [NCNT-1:0][31:0] step_count;
  logic [CCR_IRQ_W-1:0] irq_set;
  logic acc;
  logic [7:0] loc;
  logic bank;

  // Bus access: one wait cycle, then acknowledge
  assign acc = (avs_read | avs_write) & wait_reg;
  assign bank = (avs_address >= CCR_BANK_B) & (avs_address < CCR_OFF_CTRL);
  assign loc = bank ? avs_address - CCR_BANK_B : avs_address;

  // Counting, edge detection and comparator events
  always_comb
  begin
    irq_set = '0;
    for (int c = 0; c < NCNT; c++)
    begin
      up_edge[c] = pin_s2_reg[c].up_pulse & ~pin_s3_reg[c].up_pulse;
      dn_edge[c] = pin_s2_reg[c].down_dir & ~pin_s3_reg[c].down_dir;
      step_count[c] = count_reg[c];
      if (ctrl_reg[c*CCR_CTRL_STRIDE + CCR_CTRL_GATE])
      begin
        if (cfg_reg[c].mode == CCR_MODE_PULSEDIR)
        begin
          // Direction level is sampled with the pulse edge
          if (up_edge[c])
            step_count[c] = pin_s2_reg[c].down_dir ? count_reg[c] + CCR_ONE32
                                                    : count_reg[c] - CCR_ONE32;
        end
        else if (up_edge[c] != dn_edge[c])
          step_count[c] = up_edge[c] ? count_reg[c] + CCR_ONE32
                                     : count_reg[c] - CCR_ONE32;
      end
      // Signed 32-bit wrap is plain two's complement arithmetic
      ev_reach[c] = (step_count[c] != count_reg[c]) && (step_count[c] == comp_reg[c])
                    && (count_reg[c] == comp_reg[c] - CCR_ONE32);
      ev_fall[c] = (step_count[c] != count_reg[c]) && (count_reg[c] == comp_reg[c])
                   && (step_count[c] == comp_reg[c] - CCR_ONE32);
      if (ctrl_reg[c*CCR_CTRL_STRIDE + CCR_CTRL_RESET])
      begin
        ev_reach[c] = 1'b0;
        ev_fall[c] = 1'b0;
      end
      irq_set[2*c] = ev_reach[c] & cfg_reg[c].reach.irq;
      irq_set[2*c+1] = ev_fall[c] & cfg_reg[c].fall.irq;
    end
  end

  // Next-state for counters, compare values, outputs and registers
  always_comb
  begin
    logic [31:0] rd;
    logic setcmp_now;
    logic [31:0] cfg_w;
    logic [31:0] en_w;
    rd = CCR_UNMAPPED;
    setcmp_now = 1'b0;
    cfg_w = CCR_ZERO32;
    // Merged enable word; only the low event bits are kept
    en_w = be_merge(32'(irq_en_reg), avs_writedata, avs_byteenable);
    cfg_next = cfg_reg;
    rstval_next = rstval_reg;
    preset_next = preset_reg;
    ctrl_next = ctrl_reg;
    irq_en_next = irq_en_reg;
    // Set wins over clear for every status bit
    stat_next = stat_reg;
    if (acc && avs_write && avs_address == CCR_OFF_IRQ_CLR)
      stat_next = stat_reg & ~avs_writedata[CCR_IRQ_W-1:0];
    stat_next = stat_next | irq_set;
    // Register writes
    if (acc && avs_write)
    begin
      if (avs_address < CCR_OFF_CTRL)
      begin
        for (int c = 0; c < NCNT; c++)
          if ((c == 1) == bank)
            case (loc)
              CCR_OFF_CFG_A:
              begin
                cfg_w = be_merge(32'(cfg_reg[c]), avs_writedata, avs_byteenable);
                cfg_next[c] = ccr_cfg_t'(cfg_w[CCR_CFG_W-1:0]); // Upper bits dropped
              end
              CCR_OFF_RSTVAL_A: rstval_next[c] = be_merge(rstval_reg[c], avs_writedata,
                                                          avs_byteenable);
              CCR_OFF_PRESET_A: preset_next[c] = be_merge(preset_reg[c], avs_writedata,
                                                          avs_byteenable);
              default: ;
            endcase
      end
      else if (avs_address == CCR_OFF_CTRL)
        ctrl_next = be_merge(ctrl_reg, avs_writedata, avs_byteenable);
      else if (avs_address == CCR_OFF_IRQ_EN)
        irq_en_next = en_w[CCR_IRQ_W-1:0];
    end
    // Counter datapath per channel
    for (int c = 0; c < NCNT; c++)
    begin
      setcmp_now = ctrl_next[c*CCR_CTRL_STRIDE + CCR_CTRL_SETCMP];
      setcmp_old_next[c] = setcmp_now;
      count_next[c] = step_count[c];
      comp_next[c] = comp_reg[c];
      dout_next[c] = dout_reg[c];
      // Reach and fall never fire together, so order is free; all reactions apply
      if (ev_reach[c])
      begin
        dout_next[c] = do_apply(cfg_reg[c].reach.dout, dout_reg[c]);
        if (cfg_reg[c].reach.reload)
          count_next[c] = rstval_reg[c];
        if (has_react(cfg_reg[c].reach) || cfg_reg[c].reach.set_cmp)
          comp_next[c] = preset_reg[c];
      end
      if (ev_fall[c])
      begin
        dout_next[c] = do_apply(cfg_reg[c].fall.dout, dout_reg[c]);
        if (cfg_reg[c].fall.reload)
          count_next[c] = rstval_reg[c];
        if (has_react(cfg_reg[c].fall) || cfg_reg[c].fall.set_cmp)
          comp_next[c] = preset_reg[c];
      end
      if (setcmp_now && !setcmp_old_reg[c])
        comp_next[c] = preset_reg[c];
      if (ctrl_reg[c*CCR_CTRL_STRIDE + CCR_CTRL_RESET])
      begin
        count_next[c] = rstval_reg[c];
        dout_next[c] = 1'b0;
      end
    end
    irq_next = |(stat_next & irq_en_next);
    // Read mux
    if (avs_address < CCR_OFF_CTRL)
    begin
      for (int c = 0; c < NCNT; c++)
        if ((c == 1) == bank)
          case (loc)
            CCR_OFF_CFG_A: rd = 32'(cfg_reg[c]);
            CCR_OFF_RSTVAL_A: rd = rstval_reg[c];
            CCR_OFF_PRESET_A: rd = preset_reg[c];
            CCR_OFF_COUNT_A: rd = count_reg[c];
            CCR_OFF_COMP_A: rd = comp_reg[c];
            default: ;
          endcase
    end
    else
      case (avs_address)
        CCR_OFF_CTRL: rd = ctrl_reg;
        CCR_OFF_IRQ_STAT: rd = 32'(stat_reg);
        CCR_OFF_IRQ_EN: rd = 32'(irq_en_reg);
        CCR_OFF_OUT: rd = 32'(dout_reg);
        default: rd = CCR_UNMAPPED;
      endcase
    rdata_next = (acc && avs_read) ? rd : rdata_reg;
    // Waitrequest high at rest; drops for one cycle to end each access
    wait_next = ~((avs_read | avs_write) & wait_reg);
  end

  // Register all state
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int c = 0; c < NCNT; c++)
      begin
        cfg_reg[c] <= CCR_CFG_RST;
        rstval_reg[c] <= CCR_RSTVAL_RST;
        preset_reg[c] <= CCR_ZERO32;
        count_reg[c] <= CCR_RSTVAL_RST;
        comp_reg[c] <= CCR_ZERO32;
      end
      setcmp_old_reg <= '0;
      ctrl_reg <= CCR_ZERO32;
      stat_reg <= '0;
      irq_en_reg <= '0;
      dout_reg <= '0;
      irq_reg <= 1'b0;
      rdata_reg <= CCR_ZERO32;
      wait_reg <= 1'b1;
    end
    else
    begin
      cfg_reg <= cfg_next;
      rstval_reg <= rstval_next;
      preset_reg <= preset_next;
      count_reg <= count_next;
      comp_reg <= comp_next;
      setcmp_old_reg <= setcmp_old_next;
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      irq_en_reg <= irq_en_next;
      dout_reg <= dout_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
      wait_reg <= wait_next;
    end
  end

  assign digital_out = dout_reg;
  assign irq = irq_reg;
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

endmodule : ccr_top

/* src/ccr_pkg.sv */
// Package for the counter compare reaction block: register map, fields, resets
package ccr_pkg;
  // Register word offsets (byte addresses)
  localparam logic [7:0] CCR_OFF_CFG_A = 8'h00;
  localparam logic [7:0] CCR_OFF_RSTVAL_A = 8'h04;
  localparam logic [7:0] CCR_OFF_PRESET_A = 8'h08;
  localparam logic [7:0] CCR_OFF_COUNT_A = 8'h0c;
  localparam logic [7:0] CCR_OFF_COMP_A = 8'h10;
  localparam logic [7:0] CCR_OFF_CFG_B = 8'h20;
  localparam logic [7:0] CCR_OFF_RSTVAL_B = 8'h24;
  localparam logic [7:0] CCR_OFF_PRESET_B = 8'h28;
  localparam logic [7:0] CCR_OFF_COUNT_B = 8'h2c;
  localparam logic [7:0] CCR_OFF_COMP_B = 8'h30;
  localparam logic [7:0] CCR_OFF_CTRL = 8'h40;
  localparam logic [7:0] CCR_OFF_IRQ_STAT = 8'h44;
  localparam logic [7:0] CCR_OFF_IRQ_CLR = 8'h48;
  localparam logic [7:0] CCR_OFF_IRQ_EN = 8'h4c;
  localparam logic [7:0] CCR_OFF_OUT = 8'h50;
  localparam logic [7:0] CCR_BANK_B = 8'h20;
  // Control register bits, per counter c at bit base 4*c
  localparam int CCR_CTRL_GATE = 0;
  localparam int CCR_CTRL_RESET = 1;
  localparam int CCR_CTRL_SETCMP = 2;
  localparam int CCR_CTRL_STRIDE = 4;
  // Interrupt status: bit 2*c reach event, bit 2*c+1 fall event
  localparam int CCR_IRQ_W = 4;
  // Digital output actions
  localparam logic [1:0] CCR_DO_KEEP = 2'h0;
  localparam logic [1:0] CCR_DO_ON = 2'h1;
  localparam logic [1:0] CCR_DO_TOGGLE = 2'h2;
  localparam logic [1:0] CCR_DO_OFF = 2'h3;
  // Input modes
  localparam logic CCR_MODE_UPDOWN = 1'b0;
  localparam logic CCR_MODE_PULSEDIR = 1'b1;
  // Reset values, the count step and the unmapped read value
  localparam logic [31:0] CCR_RSTVAL_RST = 32'h0000_0000;
  localparam logic [31:0] CCR_ZERO32 = 32'h0000_0000;
  localparam logic [31:0] CCR_ONE32 = 32'h0000_0001;
  localparam logic [31:0] CCR_UNMAPPED = 32'h0000_0000;

  // Reaction set for one event
  typedef struct packed {
    logic set_cmp;
    logic reload;
    logic irq;
    logic [1:0] dout;
  } ccr_react_t;

  // Per-counter configuration; word layout is {mode, fall[4:0], reach[4:0]} low bits
  typedef struct packed {
    logic mode;
    ccr_react_t fall;
    ccr_react_t reach;
  } ccr_cfg_t;

  localparam ccr_cfg_t CCR_CFG_RST = '{mode: CCR_MODE_UPDOWN,
    fall: '{set_cmp: 1'b0, reload: 1'b0, irq: 1'b0, dout: CCR_DO_KEEP},
    reach: '{set_cmp: 1'b0, reload: 1'b0, irq: 1'b0, dout: CCR_DO_KEEP}};
  localparam int CCR_CFG_W = $bits(ccr_cfg_t);

  // Sensor pins of one counter
  typedef struct packed {
    logic up_pulse;
    logic down_dir;
  } ccr_pins_t;
endpackage : ccr_pkg

/* bench/ccr_chk.sv */
// Port checker for the counter compare reaction block, with its bind
`timescale 1ns/10ps
module ccr_chk
  import ccr_pkg::*;
#(
  parameter int NCNT = 2
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins and outputs
  input wire ccr_pins_t [NCNT-1:0] sensor_pins,
  input wire logic [NCNT-1:0] digital_out,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  ccr_pins_t [NCNT-1:0] pins_q;
  logic [3:0] act_age;
  // Age since a pin moved or a write was held; writes act one edge before the answer
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pins_q <= '0;
      act_age <= 4'hf;
    end
    else
    begin
      pins_q <= sensor_pins;
      if (sensor_pins != pins_q || avs_write)
        act_age <= 4'h0;
      else if (act_age != 4'hf)
        act_age <= act_age + 4'h1;
    end
  end
  property p_wait_pulse; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
  property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
  property p_wait_idle; !avs_read && !avs_write |-> avs_waitrequest; endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
  property p_rd_hold; !$past(avs_read) |-> $stable(avs_readdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rst_out; $rose(resetn) |-> digital_out == '0 && !irq; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not low at reset");
  property p_dout_cause; $changed(digital_out) |-> act_age < 4'ha; endproperty
  a_dout_cause: assert property (p_dout_cause) else $error("output moved alone");
  property p_irq_rise; $rose(irq) |-> act_age < 4'ha; endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose alone");
  property p_irq_fall; $fell(irq) |-> act_age < 4'h4; endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule : ccr_chk

bind ccr_top ccr_chk #(.NCNT(NCNT)) ccr_chk_inst (.clk_sys(clk_sys), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sensor_pins(sensor_pins), .digital_out(digital_out), .irq(irq));

/* bench/ccr_sensor_model.sv */
// Behavioural pulse sensor driving the two pins of one counter
`timescale 1ns/10ps
module ccr_sensor_model
  import ccr_pkg::*;
(
  // Command from the bench
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic [7:0] npulse,
  input wire logic slow,
  // Pins and status
  output ccr_pins_t pins,
  output logic busy
);
  int i;
  int w;
  logic dir;
  // Kinds: 0 up pin, 1 down pin, 2 pulse and dir high, 3 pulse and dir low
  initial
  begin
    pins = '0;
    busy = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      if (go)
      begin
        busy <= 1'b1;
        w = slow ? 6 : 2;
        dir = kind[1] & ~kind[0];
        // Direction settles before the first edge and holds after the last
        pins.down_dir <= dir;
        repeat (w) @(posedge clk_sys);
        for (i = 0; i < npulse; i++)
        begin
          if (kind == 2'h1)
            pins.down_dir <= 1'b1;
          else
            pins.up_pulse <= 1'b1;
          repeat (w) @(posedge clk_sys);
          pins <= {1'b0, dir};
          repeat (w) @(posedge clk_sys);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : ccr_sensor_model

/* bench/ccr_top_tb.sv */
// Self-checking bench for the counter compare reaction block
`timescale 1ns/10ps
module ccr_top_tb
  import ccr_pkg::*;
;
  logic clk_sys, resetn, avs_read, avs_write, avs_waitrequest, irq, slow;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, rst_a, pre_b;
  ccr_pins_t [1:0] sensor_pins;
  logic [1:0] digital_out, go, busy;
  logic [1:0] kind [2];
  logic [7:0] npulse [2];
  logic [7:0] offs [6] = '{CCR_OFF_CFG_A, CCR_OFF_RSTVAL_A, CCR_OFF_COMP_A, CCR_OFF_CFG_B,
    CCR_OFF_COUNT_B, 8'h60};
  int failures, checks_done, seed, k;

  ccr_top ccr_top_inst (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sensor_pins(sensor_pins), .digital_out(digital_out), .irq(irq));
  for (genvar g = 0; g < 2; g++)
  begin : g_sens
    ccr_sensor_model ccr_sensor_model_inst (.clk_sys(clk_sys), .go(go[g]), .kind(kind[g]),
      .npulse(npulse[g]), .slow(slow), .pins(sensor_pins[g]), .busy(busy[g]));
  end

  // 20 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function logic [31:0] cfg_word(input logic [1:0] a, input logic i, input logic r);
    return {27'h0, 1'b0, r, i, a};
  endfunction : cfg_word
  function logic do_exp(input logic [1:0] a, input logic prev);
    return (a == CCR_DO_ON) ? 1'b1 : (a == CCR_DO_OFF) ? 1'b0 :
           (a == CCR_DO_TOGGLE) ? ~prev : prev;
  endfunction : do_exp
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task end_of_test;
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // Request held until waitrequest is sampled low; bounded wait
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      failures++;
      end_of_test();
    end
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  // Pulse burst on one counter, then let the count settle
  task pulse(input int c, input logic [1:0] kd, input logic [7:0] n);
    @(posedge clk_sys);
    kind[c] <= kd;
    npulse[c] <= n;
    slow <= 1'($random(seed));
    go[c] <= 1'b1;
    @(posedge clk_sys);
    go[c] <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (busy[c] !== 1'b0 && k < 400);
    if (busy[c] !== 1'b0)
    begin
      failures++;
      end_of_test();
    end
    repeat (6) @(posedge clk_sys);
  endtask : pulse

  initial
  begin
    seed = 70274;
    failures = 0;
    checks_done = 0;
    {resetn, avs_read, avs_write, slow, go} = '0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    kind = '{2'h0, 2'h0};
    npulse = '{8'h0, 8'h0};
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (offs[i]) rd(offs[i], 32'h0);
    // Counter A: negative reset value, reach keeps output, fall toggles and reloads
    rst_a = 32'h0 - (32'h8 + ($random(seed) & 32'hf));
    wr(CCR_OFF_RSTVAL_A, rst_a);
    wr(CCR_OFF_PRESET_A, 32'h3);
    wr(CCR_OFF_CTRL, 32'h5);
    wr(CCR_OFF_CTRL, 32'h1);
    rd(CCR_OFF_COMP_A, 32'h3);
    wr(CCR_OFF_PRESET_A, 32'h5);
    wr(CCR_OFF_CFG_A, cfg_word(CCR_DO_KEEP, 1'b1, 1'b0) |
       (cfg_word(CCR_DO_TOGGLE, 1'b0, 1'b1) << 5));
    wr(CCR_OFF_IRQ_EN, 32'hf);
    pulse(0, 2'h0, 8'h3);
    rd(CCR_OFF_COUNT_A, 32'h3);
    rd(CCR_OFF_COMP_A, 32'h5);
    rd(CCR_OFF_IRQ_STAT, 32'h1);
    chk(32'(irq), 32'h1);
    chk(32'(digital_out[0]), 32'(do_exp(CCR_DO_KEEP, 1'b0)));
    wr(CCR_OFF_IRQ_CLR, 32'h1);
    rd(CCR_OFF_IRQ_STAT, 32'h0);
    chk(32'(irq), 32'h0);
    pulse(0, 2'h0, 8'h2);
    pulse(0, 2'h1, 8'h1);
    rd(CCR_OFF_COUNT_A, rst_a);
    chk(32'(digital_out[0]), 32'(do_exp(CCR_DO_TOGGLE, 1'b0)));
    wr(CCR_OFF_IRQ_EN, 32'h0);
    rd(CCR_OFF_IRQ_STAT, 32'h1);
    chk(32'(irq), 32'h0);
    wr(CCR_OFF_CTRL, 32'h0);
    pulse(0, 2'h0, 8'h2);
    rd(CCR_OFF_COUNT_A, rst_a);
    // Counter B: pulse and direction, reach sets, fall clears
    pre_b = 32'(($random(seed) & 3) + 2);
    wr(CCR_OFF_PRESET_B, pre_b);
    wr(CCR_OFF_CTRL, 32'h50);
    wr(CCR_OFF_CTRL, 32'h10);
    wr(CCR_OFF_CFG_B, 32'h400 | cfg_word(CCR_DO_ON, 1'b0, 1'b0) |
       (cfg_word(CCR_DO_OFF, 1'b0, 1'b0) << 5));
    pulse(1, 2'h2, pre_b[7:0]);
    rd(CCR_OFF_COUNT_B, pre_b);
    chk(32'(digital_out[1]), 32'(do_exp(CCR_DO_ON, 1'b0)));
    pulse(1, 2'h3, 8'h1);
    rd(CCR_OFF_COUNT_B, pre_b - 32'h1);
    chk(32'(digital_out[1]), 32'(do_exp(CCR_DO_OFF, 1'b1)));
    pulse(1, 2'h2, 8'h1);
    wr(CCR_OFF_CTRL, 32'h30);
    rd(CCR_OFF_COUNT_B, 32'h0);
    chk(32'(digital_out[1]), 32'h0);
    pulse(1, 2'h3, 8'h1);
    rd(CCR_OFF_COUNT_B, 32'h0);
    chk(32'(digital_out[1]), 32'h0);
    rd(CCR_OFF_COUNT_A, rst_a);
    // Counter A: compare set alone takes the preset, output left as it was
    wr(CCR_OFF_PRESET_A, rst_a + 32'h1);
    wr(CCR_OFF_CTRL, 32'h5);
    wr(CCR_OFF_PRESET_A, 32'h77);
    wr(CCR_OFF_CFG_A, 32'h10);
    pulse(0, 2'h0, 8'h1);
    rd(CCR_OFF_COUNT_A, rst_a + 32'h1);
    rd(CCR_OFF_COMP_A, 32'h77);
    chk(32'(digital_out[0]), 32'(do_exp(CCR_DO_KEEP, 1'b1)));
    end_of_test();
  end
endmodule : ccr_top_tb
